//--- src/sync_burst_sram_access_control.sv
`timescale 1ns/1ps
`include "sram_ctl_params.svh"
// Memory timing is modelled one register deep: the address registered on an edge is read
// from the store on the following edge, and the data pins are driven from flops after that.
module sync_burst_sram_access_control #(
  parameter int ADDR_W = 8,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // address and selects
  input wire logic [ADDR_W-1:0] addr,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_depth_hi,
  input wire logic chip_select_depth_n,
  // burst control
  input wire logic processor_strobe_n,
  input wire logic controller_strobe_n,
  input wire logic burst_step_n,
  input wire sram_ctl_pkg::burst_order_t burst_order,
  // write control
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  // data pins, three-signal form
  input wire logic [LANES*LANE_W-1:0] data_in,
  output logic [LANES*LANE_W-1:0] data_out,
  output logic data_oe,
  input wire logic output_enable_n,
  // sleep
  input wire logic sleep_request,
  output logic asleep,
  output logic access_invalid
);
  import sram_ctl_pkg::*;

  // the burst counter needs at least two address bits, and every lane at least one bit
  if (ADDR_W < `BURST_CNT_W || LANES < 1 || LANE_W < 1) begin : g_bad_widths
    $error("sram access control: unsupported width parameters");
  end

  // input registers for every synchronous input
  logic [ADDR_W-1:0] addr_ff;
  logic cs1_n_ff, cs2_ff, cs3_n_ff, psn_ff, csn_ff, adv_n_ff, gw_n_ff, bwe_n_ff;
  logic [LANES-1:0] bsel_n_ff;
  logic [LANES*LANE_W-1:0] din_ff;
  logic order_ff, sleep_ff;
  always_ff @(posedge core_clk) begin
    addr_ff <= addr;
    cs1_n_ff <= chip_select_primary_n;
    cs2_ff <= chip_select_depth_hi;
    cs3_n_ff <= chip_select_depth_n;
    psn_ff <= processor_strobe_n;
    csn_ff <= controller_strobe_n;
    adv_n_ff <= burst_step_n;
    gw_n_ff <= global_write_n;
    bwe_n_ff <= byte_write_enable_n;
    bsel_n_ff <= byte_lane_select_n;
    din_ff <= data_in;
    order_ff <= (burst_order == interleaved_order);
    sleep_ff <= sleep_request;
  end

  // decode of the registered cycle
  logic all_sel, p_start, c_start, start, wr_ind, awake;
  sleep_state_t sleep_st_ff;
  assign awake = (sleep_st_ff == st_awake);
  assign all_sel = !cs1_n_ff && cs2_ff && !cs3_n_ff;
  // processor strobe only counts with primary select low; it wins over the controller strobe
  // with primary select high the processor strobe counts as not asserted, so such a
  // cycle still continues or suspends an open burst instead of being lost
  logic proc_strobe_off;
  assign proc_strobe_off = psn_ff || cs1_n_ff;
  assign p_start = awake && !psn_ff && !cs1_n_ff && all_sel;
  assign c_start = awake && proc_strobe_off && !csn_ff && all_sel;
  assign start = p_start || c_start;
  assign wr_ind = !gw_n_ff || (!bwe_n_ff && (bsel_n_ff != {LANES{1'b1}}));

  // burst counter state
  logic [ADDR_W-1:0] base_ff;
  logic [`BURST_CNT_W-1:0] first_ff, beat_ff;
  logic active_ff, after_p_ff;
  logic [`BURST_CNT_W-1:0] nxt_beat;
  logic [`BURST_CNT_W-1:0] cur_low;
  assign nxt_beat = beat_ff + 2'h1;
  always_comb begin
    if (order_ff) begin
      cur_low = first_ff ^ beat_ff;
    end else begin
      cur_low = first_ff + beat_ff;
    end
  end

  // load on start, step on burst-step low, hold on high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      active_ff <= 1'b0;
      beat_ff <= `BEAT_ZERO;
      first_ff <= `BEAT_ZERO;
      base_ff <= '0;
    end else if (start) begin
      base_ff <= addr_ff;
      first_ff <= addr_ff[`BURST_CNT_W-1:0];
      beat_ff <= `BEAT_ZERO;
      active_ff <= 1'b1;
    end else if (!awake) begin
      active_ff <= 1'b0;
    end else if (active_ff && proc_strobe_off && csn_ff && !adv_n_ff) begin
      beat_ff <= nxt_beat;
    end
  end

  // remember a processor start so the next cycle may write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      after_p_ff <= 1'b0;
    end else begin
      after_p_ff <= p_start;
    end
  end

  // the address presented to the store this cycle
  logic [ADDR_W-1:0] mem_addr;
  logic cont;
  assign cont = active_ff && awake && !start && proc_strobe_off && csn_ff;
  always_comb begin
    if (start) begin
      mem_addr = addr_ff;
    end else if (!adv_n_ff) begin
      mem_addr = {base_ff[ADDR_W-1:`BURST_CNT_W], first_ff ^ nxt_beat};
      if (!order_ff) begin
        mem_addr[`BURST_CNT_W-1:0] = first_ff + nxt_beat;
      end
    end else begin
      mem_addr = {base_ff[ADDR_W-1:`BURST_CNT_W], cur_low};
    end
  end

  // write qualification: processor start is always a read
  logic do_write;
  logic [LANES-1:0] lane_we;
  assign do_write = awake && wr_ind && !p_start && (c_start || cont || after_p_ff);
  for (genvar g = 0; g < LANES; g++) begin : g_we
    assign lane_we[g] = do_write && (!gw_n_ff || (!bwe_n_ff && !bsel_n_ff[g]));
  end

  // sleep gating writes keeps contents intact
  logic [LANES*LANE_W-1:0] rdata_ff;
  sram_store #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) sram_store_inst (
    .core_clk(core_clk),
    .addr(mem_addr),
    .lane_we(lane_we),
    .wdata(din_ff),
    .rdata_ff(rdata_ff)
  );

  // read valid pipeline matches the store's read register
  logic rd_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_ff <= 1'b0;
    end else begin
      rd_ff <= awake && (start || cont) && !do_write;
    end
  end

  // data pins: drive only for reads with output enable low; writes force float
  // output enable is resampled here since outputs must come from flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_oe <= 1'b0;
      data_out <= '0;
    end else begin
      data_out <= rdata_ff;
      data_oe <= rd_ff && !do_write && awake && !output_enable_n;
    end
  end

  // sleep: two cycles to enter and two to leave
  logic [1:0] sleep_cnt_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sleep_st_ff <= st_awake;
      sleep_cnt_ff <= 2'h0;
    end else begin
      unique case (sleep_st_ff)
        st_awake: if (sleep_ff) begin
          sleep_st_ff <= st_entering;
          sleep_cnt_ff <= 2'h1;
        end
        st_entering: if (sleep_cnt_ff == 2'(`SLEEP_ENTRY_CYCLES - 1)) begin
          sleep_st_ff <= st_asleep;
        end else begin
          sleep_cnt_ff <= sleep_cnt_ff + 2'h1;
        end
        st_asleep: if (!sleep_ff) begin
          sleep_st_ff <= st_leaving;
          sleep_cnt_ff <= 2'h1;
        end
        st_leaving: if (sleep_cnt_ff == 2'(`SLEEP_EXIT_CYCLES - 1)) begin
          sleep_st_ff <= st_awake;
        end else begin
          sleep_cnt_ff <= sleep_cnt_ff + 2'h1;
        end
      endcase
    end
  end

  // status outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      asleep <= 1'b0;
      access_invalid <= 1'b0;
    end else begin
      asleep <= (sleep_st_ff == st_asleep);
      access_invalid <= (sleep_st_ff == st_awake) && sleep_ff && active_ff;
    end
  end

  chk_pstart_read: assert property (@(posedge core_clk) disable iff (rst)
    p_start |-> lane_we == '0) else $error("write on processor start");
  chk_lane_global: assert property (@(posedge core_clk) disable iff (rst)
    (do_write && !gw_n_ff) |-> (&lane_we)) else $error("global write missed lanes");
  chk_lane_byte: assert property (@(posedge core_clk) disable iff (rst)
    (do_write && gw_n_ff) |-> ((lane_we & bsel_n_ff) == '0))
    else $error("unselected lane written");
  chk_float_write: assert property (@(posedge core_clk) disable iff (rst)
    do_write |=> !data_oe) else $error("pins driven during write");
  chk_sleep_entry: assert property (@(posedge core_clk) disable iff (rst)
    (sleep_st_ff == st_awake && sleep_ff) |=> ##1 (sleep_st_ff == st_asleep))
    else $error("sleep entry not two cycles");
  chk_sleep_nowrite: assert property (@(posedge core_clk) disable iff (rst)
    !awake |-> lane_we == '0) else $error("write while asleep");
  chk_ce1_ignore: assert property (@(posedge core_clk) disable iff (rst)
    cs1_n_ff |-> !start) else $error("start with primary select high");
  chk_burst_hold: assert property (@(posedge core_clk) disable iff (rst)
    (active_ff && !start && psn_ff && csn_ff && adv_n_ff) |=> $stable(beat_ff))
    else $error("burst moved while suspended");
  chk_burst_load: assert property (@(posedge core_clk) disable iff (rst)
    start |=> (beat_ff == `BEAT_ZERO && first_ff == $past(addr_ff[1:0])))
    else $error("burst counter not loaded");
  // the pins follow the enable seen one cycle after the start, unless a write takes over
  chk_read_drive: assert property (@(posedge core_clk) disable iff (rst)
    (p_start ##1 (awake && !do_write && !output_enable_n)) |=> data_oe)
    else $error("read not driven");

  // leaving sleep takes two edges once the request has dropped
  chk_sleep_exit: assert property (@(posedge core_clk) disable iff (rst)
    (sleep_st_ff == st_asleep && !sleep_ff) |=> ##1 (sleep_st_ff == st_awake))
    else $error("sleep exit not two cycles");

  // an advance cycle moves the beat by exactly one, wrapping at four
  chk_burst_step: assert property (@(posedge core_clk) disable iff (rst)
    (active_ff && awake && !start && proc_strobe_off && csn_ff && !adv_n_ff)
    |=> (beat_ff == $past(beat_ff) + 2'h1)) else $error("burst did not advance");

  // controller start with write indicated writes in the same cycle
  chk_ctl_write: assert property (@(posedge core_clk) disable iff (rst)
    (c_start && wr_ind) |-> (lane_we != '0)) else $error("controller write lost");

  // the cycle after a processor start writes if the controls say so
  chk_late_write: assert property (@(posedge core_clk) disable iff (rst)
    (after_p_ff && !start && wr_ind && awake) |-> (lane_we != '0))
    else $error("write after processor start lost");

  // both strobes low: only the processor strobe starts the access
  chk_strobe_both: assert property (@(posedge core_clk) disable iff (rst)
    (awake && all_sel && !psn_ff && !csn_ff) |-> (p_start && !c_start))
    else $error("controller strobe acted on");

  // pins stay released whenever output enable was high
  chk_oe_masked: assert property (@(posedge core_clk) disable iff (rst)
    output_enable_n |=> !data_oe) else $error("pins driven with enable high");
endmodule // sync_burst_sram_access_control

//--- common/sram_ctl_params.svh
// Summary of operation
// - every synchronous input is captured in input registers on the rising edge
// - a 2-bit wraparound counter holds the burst start and makes later addresses
// - the counter loads from the two lowest address bits; only those sequence
// - burst stepping follows the burst-step input sampled each edge
// - order low selects linear order: next address is previous plus one mod four
// - order high selects interleaved order: start address xor beat count
// - processor strobe is ignored while primary chip select is high
// - all chip selects active and a strobe low start an access and load address
// - pipelined read drives addressed data two edges after the address registered
// - processor-strobe start ignores write controls and is a read
// - after processor start, a write indicated at the next edge writes the address
// - controller strobe with processor strobe high and write indicated writes at once
// - byte writes use byte write enable and per-lane selects; only those lanes written
// - global write overrides byte controls and writes every lane
// - data pins float once a write is detected, whatever output enable says
// - sleep request enters low-power sleep; entry and exit each take two cycles
// - memory contents are kept intact while asleep
// - an access pending at sleep entry need not complete and is invalid
// - with both strobes low, only the processor strobe is acted on
// - write when global write low, or byte enable low with any lane select low
// - no strobe: burst-step high suspends on current address, low advances
`ifndef SRAM_CTL_PARAMS_SVH
`define SRAM_CTL_PARAMS_SVH
`define SLEEP_ENTRY_CYCLES 2
`define SLEEP_EXIT_CYCLES 2
`define BURST_CNT_W 2
`define BEAT_ZERO 2'h0
`endif

//--- common/sram_ctl_pkg.sv
package sram_ctl_pkg;
  typedef enum logic [1:0] {linear_order, interleaved_order} burst_order_t;
  typedef enum {st_awake, st_entering, st_asleep, st_leaving} sleep_state_t;
endpackage

//--- src/sram_store.sv
`timescale 1ns/1ps
// byte-lane memory; read data come out of a register
module sram_store #(
  parameter int ADDR_W = 8,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  input wire logic core_clk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES-1:0] lane_we,
  input wire logic [LANES*LANE_W-1:0] wdata,
  output logic [LANES*LANE_W-1:0] rdata_ff
);
  // one array per lane, so each array and its read slice have a single writing process;
  // lanes not enabled keep their contents
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];
    always_ff @(posedge core_clk) begin
      if (lane_we[g]) begin
        lane_mem[addr] <= wdata[g*LANE_W +: LANE_W];
      end
      rdata_ff[g*LANE_W +: LANE_W] <= lane_mem[addr];
    end
  end
endmodule // sram_store

//--- sim/bus_master.sv
`timescale 1ns/1ps
// far-side master: every cyc call presents one bus cycle just after a rising edge
module bus_master (
  // clock
  input wire logic core_clk,
  // address, selects, strobes
  output logic [7:0] addr,
  output logic chip_select_primary_n,
  output logic chip_select_depth_hi,
  output logic chip_select_depth_n,
  output logic processor_strobe_n,
  output logic controller_strobe_n,
  output logic burst_step_n,
  // write control, data, sleep
  output logic global_write_n,
  output logic byte_write_enable_n,
  output logic [3:0] byte_lane_select_n,
  output logic [35:0] data_in,
  output logic output_enable_n,
  output logic sleep_request
);
  logic rude = 1'b0; // set only to hold output enable low across a write
  logic is_wr;

  // idle levels from time zero
  initial begin
    {chip_select_primary_n, chip_select_depth_hi, chip_select_depth_n} = 3'h5;
    {processor_strobe_n, controller_strobe_n, burst_step_n, output_enable_n} = 4'hf;
    {global_write_n, byte_write_enable_n, byte_lane_select_n} = 6'h3f;
    addr = 8'h00;
    data_in = 36'h0;
    sleep_request = 1'b0;
  end

  // c = {primary_n, depth_hi, depth_n}, s = {processor_n, controller_n}
  task automatic cyc(input logic [2:0] c, input logic [1:0] s, input logic st,
                     input logic [5:0] w, input logic [7:0] a, input logic [35:0] d);
    @(posedge core_clk);
    #1;
    {chip_select_primary_n, chip_select_depth_hi, chip_select_depth_n} = c;
    {processor_strobe_n, controller_strobe_n} = s;
    burst_step_n = st;
    {global_write_n, byte_write_enable_n, byte_lane_select_n} = w;
    addr = a;
    is_wr = !w[5] || (!w[4] && w[3:0] != 4'hf);
    output_enable_n = is_wr && !rude;
    // a released bus changes every cycle so stale data never looks valid
    data_in = is_wr ? d : ~data_in;
  endtask

  // deselect: controller strobe with primary select high starts nothing
  task automatic idle();
    cyc(3'h5, 2'h2, 1'b1, 6'h3f, 8'h00, 36'h0);
  endtask

  // sleep moves only while deselected; two quiet cycles after release
  task automatic zz(input logic v);
    cyc(3'h5, 2'h3, 1'b1, 6'h3f, 8'h00, 36'h0);
    sleep_request = v;
    if (!v) repeat (2) cyc(3'h5, 2'h3, 1'b1, 6'h3f, 8'h00, 36'h0);
  endtask
endmodule // bus_master

//--- sim/sync_burst_sram_access_control_tb.sv
`timescale 1ns/1ps
module sync_burst_sram_access_control_tb;
  logic core_clk, rst, chip_select_primary_n, chip_select_depth_hi, chip_select_depth_n;
  logic processor_strobe_n, controller_strobe_n, burst_step_n, global_write_n;
  logic byte_write_enable_n, output_enable_n, sleep_request, data_oe, asleep, access_invalid;
  logic [7:0] addr;
  logic [3:0] byte_lane_select_n;
  logic [35:0] data_in, data_out;
  logic [35:0] exp_mem [256];
  sram_ctl_pkg::burst_order_t order;
  int num_errors = 0;
  int check_count = 0;

  sync_burst_sram_access_control sync_burst_sram_access_control_inst (
    .core_clk(core_clk), .rst(rst), .addr(addr), .chip_select_primary_n(chip_select_primary_n),
    .chip_select_depth_hi(chip_select_depth_hi), .chip_select_depth_n(chip_select_depth_n),
    .processor_strobe_n(processor_strobe_n), .controller_strobe_n(controller_strobe_n),
    .burst_step_n(burst_step_n), .burst_order(order), .global_write_n(global_write_n),
    .byte_write_enable_n(byte_write_enable_n), .byte_lane_select_n(byte_lane_select_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request), .asleep(asleep),
    .access_invalid(access_invalid));

  bus_master bus_master_inst (
    .core_clk(core_clk), .addr(addr), .chip_select_primary_n(chip_select_primary_n),
    .chip_select_depth_hi(chip_select_depth_hi), .chip_select_depth_n(chip_select_depth_n),
    .processor_strobe_n(processor_strobe_n), .controller_strobe_n(controller_strobe_n),
    .burst_step_n(burst_step_n), .global_write_n(global_write_n),
    .byte_write_enable_n(byte_write_enable_n), .byte_lane_select_n(byte_lane_select_n),
    .data_in(data_in), .output_enable_n(output_enable_n), .sleep_request(sleep_request));

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // expected store follows only the lanes the write controls select
  task automatic put(input logic [7:0] a, input logic [35:0] d, input logic [5:0] w);
    for (int g = 0; g < 4; g++)
      if (!w[5] || (!w[4] && !w[g])) exp_mem[a][g*9+:9] = d[g*9+:9];
  endtask

  task automatic wr(input logic [2:0] c, input logic [7:0] a, input logic [35:0] d,
                    input logic [5:0] w);
    bus_master_inst.cyc(c, 2'h2, 1'b1, w, a, d);
    if (c == 3'h2) put(a, d, w);
  endtask

  // read start, three edges, then the driven word
  task automatic rd(input logic [7:0] a, input logic [1:0] s, input logic [5:0] w);
    bus_master_inst.cyc(3'h2, s, 1'b1, w, a, ~exp_mem[a]);
    repeat (3) bus_master_inst.idle();
    chk("read enable", 36'h1, 36'(data_oe));
    chk("read data", exp_mem[a], data_out);
  endtask

  // bounded wait on a sleep flag; running out ends the run
  task automatic wait_for(input string what, input int which, input logic v);
    logic got;
    got = ~v;
    for (int i = 0; i < 8 && got !== v; i++) begin
      @(posedge core_clk);
      #1;
      got = which ? access_invalid : asleep;
    end
    chk(what, 36'(v), 36'(got));
    if (got !== v) complete_run();
  endtask

  task automatic t_basic();
    wr(3'h2, 8'h20, 36'h123456789, 6'h1f);
    wr(3'h2, 8'h21, 36'h9abcdef01, 6'h20);
    wr(3'h0, 8'h20, 36'h0, 6'h00);
    rd(8'h20, 2'h0, 6'h00);
    bus_master_inst.cyc(3'h2, 2'h1, 1'b1, 6'h3f, 8'h21, 36'h0);
    bus_master_inst.rude = 1'b1;
    bus_master_inst.cyc(3'h2, 2'h3, 1'b1, 6'h2b, 8'h21, 36'h5a5a5a5a5);
    bus_master_inst.rude = 1'b0;
    put(8'h21, 36'h5a5a5a5a5, 6'h2b);
    // the processor-start read would drive at this edge, were the write not detected
    repeat (2) bus_master_inst.idle();
    chk("write float", 36'h0, 36'(data_oe));
    rd(8'h21, 2'h1, 6'h3f);
    // ignored strobe: the open burst on 8'h21 is suspended and re-read, 8'h20 is not loaded
    bus_master_inst.cyc(3'h6, 2'h1, 1'b1, 6'h3f, 8'h20, 36'h0);
    repeat (3) bus_master_inst.idle();
    chk("ignored strobe enable", 36'h1, 36'(data_oe));
    chk("ignored strobe", exp_mem[8'h21], data_out);
    $display("test basic done");
  endtask

  // third beat suspends, so offsets run 0,1,1,2 from the start
  task automatic t_burst(input sram_ctl_pkg::burst_order_t o, input logic [1:0] s);
    logic [1:0] beat [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    logic [7:0] a;
    order = o;
    bus_master_inst.cyc(3'h2, 2'h2, 1'b1, 6'h3f, {6'h04, s}, 36'h0);
    for (int k = 1; k <= 6; k++) begin
      if (k <= 3) bus_master_inst.cyc(3'h5, 2'h3, k == 2, 6'h3f, 8'hff, 36'h0);
      else bus_master_inst.idle();
      if (k >= 3) begin
        a = {6'h04, (o == sram_ctl_pkg::interleaved_order) ? s ^ beat[k-3] : s + beat[k-3]};
        chk("burst data", exp_mem[a], data_out);
      end
    end
    $display("test burst done");
  endtask

  task automatic t_sleep();
    bus_master_inst.cyc(3'h2, 2'h2, 1'b1, 6'h3f, 8'h12, 36'h0);
    bus_master_inst.zz(1'b1);
    wait_for("pending access flagged", 1, 1'b1);
    wait_for("asleep", 0, 1'b1);
    bus_master_inst.zz(1'b0);
    wait_for("awake", 0, 1'b0);
    rd(8'h12, 2'h1, 6'h3f);
    $display("test sleep done");
  endtask

  initial begin
    rst = 1'b1;
    order = sram_ctl_pkg::linear_order;
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk("reset drive", 36'h0, 36'(data_oe));
    t_basic();
    for (int i = 0; i < 4; i++) wr(3'h2, 8'h10 + 8'(i), 36'h0c3c3c3c0 + 36'(i), 6'h1f);
    t_burst(sram_ctl_pkg::linear_order, 2'h1);
    t_burst(sram_ctl_pkg::linear_order, 2'h3);
    t_burst(sram_ctl_pkg::interleaved_order, 2'h1);
    t_burst(sram_ctl_pkg::interleaved_order, 2'h3);
    t_sleep();
    complete_run();
  end
endmodule // sync_burst_sram_access_control_tb
